//--- hw/rcs_seq.sv
// How it works
// - Nibble entry sets request and idle, silently
// - Nibble mode: data inputs, status lines carry nibble
// - Write while idle loads byte, clears idle
// - Low nibble valid, ack low, then high nibble
// - High nibble held, ack low, restore software lines
// - Pair done: idle or reload, ack high, resume
// - Nibble mode: select and init edges flagged
// - Nibble mode: badly timed select drop is illegal
// - Host byte entry: inputs, idle clear, wait
// - Host byte: autofd low, ack low, latch data
// - Host byte: strobe high after hold, check fault
// - Host byte mode raises no status events
// - Peripheral byte entry sets request and idle
// - Peripheral byte drives data while select high
// - Peripheral byte: setup, ack low, await autofd
// - Request still set means idle until written
// - Strobe rise then autofd low reloads byte
// - Select drop outside strobe window is illegal
// - Peripheral byte: select and init edges flagged
// - Nibble bit order busy, perror, select, fault
//
// Purpose: Reverse channel handshake sequencer with APB registers
// Assumes: Pins synchronous to REF_CLK_IN
// Notes: Status edges are sticky bits, write one to clear
//
// The address map and the APB register port are this design's own decisions.
`timescale 1ns/100ps
`include "rcs_defines.svh"
module rcs_seq
#(
    parameter int SETUP_CYC = `RCS_SETUP_CYC
)
(
    input wire logic REF_CLK_IN,
    input wire logic RST_N_IN,
    input wire logic CLK_EN_IN,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [11:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    input wire rcs_pkg::rcs_lines_in_t LINES_IN,
    output rcs_pkg::rcs_lines_out_t LINES_OUT,
    input wire logic [7:0] DATA_IN,
    output logic [7:0] DATA_OUT,
    output logic [7:0] DATA_OE_N_OUT
);
    import rcs_pkg::*;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire acc = PSEL_IN && PENABLE_IN && CLK_EN_IN;
    wire wr = acc && PWRITE_IN;
    wire hit_ctrl = PADDR_IN == `RCS_OFF_CTRL;
    wire hit_ohr = PADDR_IN == `RCS_OFF_OHR;
    wire hit_ior = PADDR_IN == `RCS_OFF_IOR;
    wire hit_stat = PADDR_IN == `RCS_OFF_STAT;
    wire hit_lines = PADDR_IN == `RCS_OFF_LINES;
    wire hit_sedge = PADDR_IN == `RCS_OFF_SEDGE;
    wire mapped = hit_ctrl | hit_ohr | hit_ior | hit_stat | hit_lines | hit_sedge;
    wire wr_ohr = wr && hit_ohr;

    rcs_mode_t mode_q;
    rcs_state_t st_q, st_d;
    rcs_lines_out_t sw_q;
    rcs_lines_in_t prev_q;
    logic [7:0] ohr_q, ior_q, dir_q, pdata_q;
    logic ohr_full_q, data_request_flag_q, idle_q, ill_q, hi_nib_q, nib_on_q;
    logic auto_q, strobe_q, ack_q;
    logic [3:0] sedge_q;
    logic [15:0] cnt_q;
    logic win_q;

    assign PREADY_OUT = 1'b1;
    assign PSLVERR_OUT = PSEL_IN && PENABLE_IN && !mapped;

    // ------------------------------------------------------------
    // Pin and timer helpers
    // ------------------------------------------------------------
    wire cnt_done = cnt_q >= 16'(SETUP_CYC);
    wire fd_n = LINES_IN.auto_fd_n;
    wire sel_fall = prev_q.select_in_n && !LINES_IN.select_in_n;
    wire strobe_rise = !prev_q.strobe_n && LINES_IN.strobe_n;
    wire fd_fall = prev_q.auto_fd_n && !fd_n;
    wire in_nib = mode_q == RCS_MODE_PNIB;
    wire in_pbyte = mode_q == RCS_MODE_PBYTE;
    wire in_hbyte = mode_q == RCS_MODE_HBYTE;
    wire ctrl_wr = wr && hit_ctrl;
    wire [1:0] new_mode = PWDATA_IN[1:0];
    wire [3:0] nib_val = hi_nib_q ? ior_q[7:4] : ior_q[3:0];
    // Byte pending: written by software and not yet loaded
    wire pend = ohr_full_q;

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    logic load, take_in, set_idle, clr_idle, restart;
    always_comb
    begin
        st_d = st_q;
        load = 1'b0;
        take_in = 1'b0;
        set_idle = 1'b0;
        clr_idle = 1'b0;
        restart = 1'b0;
        unique case (st_q)
            RCS_S_IDLE:
            begin
                if ((in_nib || in_pbyte) && idle_q && pend)
                begin
                    load = 1'b1;
                    clr_idle = 1'b1;
                    st_d = RCS_S_SETUP;
                    restart = 1'b1;
                end
            end
            RCS_S_START:
                if (cnt_done)
                    st_d = RCS_S_STROBE;
            RCS_S_SETUP:
                if (cnt_done)
                    st_d = RCS_S_ACKLO;
            RCS_S_ACKLO:
                if (fd_n)
                begin
                    if (in_nib)
                        st_d = RCS_S_WAITLO;
                    else if (pend)
                        st_d = RCS_S_RISE;
                    else
                    begin
                        set_idle = 1'b1;
                        st_d = RCS_S_HWAIT;
                    end
                    restart = 1'b1;
                end
            RCS_S_HWAIT:
                if (pend)
                begin
                    clr_idle = 1'b1;
                    st_d = RCS_S_RISE;
                end
            RCS_S_RISE:
                if (strobe_rise)
                    st_d = RCS_S_WAITHI;
            RCS_S_WAITHI:
                if (in_pbyte && !fd_n)
                begin
                    load = 1'b1;
                    st_d = RCS_S_SETUP;
                    restart = 1'b1;
                end
            RCS_S_WAITLO:
                if (cnt_done && !fd_n)
                    st_d = RCS_S_HIGHLO;
            RCS_S_HIGHLO:
                if (fd_n)
                begin
                    if (pend)
                    begin
                        load = 1'b1;
                        clr_idle = 1'b1;
                        restart = 1'b1;
                        st_d = RCS_S_REST;
                    end
                    else
                    begin
                        set_idle = 1'b1;
                        st_d = RCS_S_HIGHWT;
                    end
                end
            RCS_S_HIGHWT:
                if (pend)
                begin
                    load = 1'b1;
                    clr_idle = 1'b1;
                    restart = 1'b1;
                    st_d = RCS_S_REST;
                end
            RCS_S_REST:
                if (cnt_done && !fd_n)
                begin
                    restart = 1'b1;
                    st_d = RCS_S_SETUP;
                end
            RCS_S_STROBE:
                if (!LINES_IN.ack_n && !data_request_flag_q)
                begin
                    take_in = 1'b1;
                    restart = 1'b1;
                    st_d = RCS_S_SWAIT;
                end
            RCS_S_SWAIT:
                if (!data_request_flag_q && LINES_IN.ack_n && cnt_done)
                begin
                    if (!LINES_IN.fault_n)
                        st_d = RCS_S_STROBE;
                    else
                    begin
                        set_idle = 1'b1;
                        st_d = RCS_S_IDLE;
                    end
                end
            default:
                st_d = RCS_S_IDLE;
        endcase
    end

    // Phase-driven line values
    wire ack_low = st_q == RCS_S_ACKLO || st_q == RCS_S_HIGHLO || st_q == RCS_S_HWAIT
        || st_q == RCS_S_HIGHWT || (st_q == RCS_S_REST && !cnt_done);
    wire fd_low = st_q == RCS_S_STROBE;
    wire strobe_low = st_q == RCS_S_SWAIT;

    // ------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------
    always_ff @(posedge REF_CLK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
        begin
            st_q <= RCS_S_IDLE;
            mode_q <= RCS_MODE_SW;
            cnt_q <= 16'h0000;
            prev_q <= '1;
            hi_nib_q <= 1'b0;
            nib_on_q <= 1'b0;
            win_q <= 1'b0;
        end
        else if (CLK_EN_IN)
        begin
            prev_q <= LINES_IN;
            if (ctrl_wr)
            begin
                mode_q <= rcs_mode_t'(new_mode);
                st_q <= rcs_mode_t'(new_mode) == RCS_MODE_HBYTE ? RCS_S_START : RCS_S_IDLE;
                cnt_q <= 16'h0000;
                hi_nib_q <= 1'b0;
                nib_on_q <= rcs_mode_t'(new_mode) == RCS_MODE_PNIB;
                win_q <= 1'b0;
            end
            else
            begin
                st_q <= st_d;
                cnt_q <= restart ? 16'h0000 : (cnt_done ? cnt_q : cnt_q + 16'h0001);
                if (st_q == RCS_S_ACKLO && st_d == RCS_S_WAITLO)
                    hi_nib_q <= 1'b1;
                if (st_q == RCS_S_REST && st_d == RCS_S_SETUP)
                    hi_nib_q <= 1'b0;
                if (st_q == RCS_S_HIGHLO && fd_n)
                    nib_on_q <= 1'b0;
                if (st_q == RCS_S_REST && st_d == RCS_S_SETUP)
                    nib_on_q <= 1'b1;
                if (strobe_rise)
                    win_q <= 1'b1;
                else if (fd_fall)
                    win_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Data path and flags
    // ------------------------------------------------------------
    wire enter_req = ctrl_wr && (new_mode == RCS_MODE_PNIB || new_mode == RCS_MODE_PBYTE);
    wire nib_bad = in_nib && sel_fall
        && (st_q == RCS_S_SETUP || st_q == RCS_S_ACKLO || st_q == RCS_S_HIGHLO
        || st_q == RCS_S_HIGHWT || st_q == RCS_S_REST);
    wire pb_bad = in_pbyte && sel_fall && !win_q;
    wire edges = (in_nib || in_pbyte) && !in_hbyte;
    wire [3:0] sev = {prev_q.init_n & !LINES_IN.init_n, !prev_q.init_n & LINES_IN.init_n,
        sel_fall, !prev_q.select_in_n & LINES_IN.select_in_n};
    wire [3:0] sclr = (wr && hit_sedge) ? PWDATA_IN[3:0] : 4'h0;

    always_ff @(posedge REF_CLK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
        begin
            ohr_q <= 8'h00;
            ohr_full_q <= 1'b0;
            ior_q <= 8'h00;
            data_request_flag_q <= 1'b0;
            idle_q <= 1'b0;
            ill_q <= 1'b0;
            sw_q <= '1;
            dir_q <= 8'h00;
            pdata_q <= 8'h00;
            sedge_q <= 4'h0;
            auto_q <= 1'b1;
            strobe_q <= 1'b1;
            ack_q <= 1'b1;
        end
        else if (CLK_EN_IN)
        begin
            auto_q <= !fd_low;
            strobe_q <= !strobe_low;
            ack_q <= !ack_low;
            if (wr_ohr)
            begin
                ohr_q <= PWDATA_IN[7:0];
                ohr_full_q <= 1'b1;
            end
            else if (load)
                ohr_full_q <= 1'b0;
            if (load)
                ior_q <= ohr_q;
            else if (take_in)
                ior_q <= DATA_IN;
            // Every load asks for the next byte, the first one after idle too
            if (enter_req || take_in || load)
                data_request_flag_q <= 1'b1;
            else if (wr_ohr || (wr && hit_ior) || (!wr && acc && hit_ior))
                data_request_flag_q <= 1'b0;
            if (enter_req || set_idle)
                idle_q <= 1'b1;
            else if (clr_idle || (ctrl_wr && new_mode == RCS_MODE_HBYTE))
                idle_q <= 1'b0;
            if (nib_bad || pb_bad)
                ill_q <= 1'b1;
            else if (wr && hit_stat && PWDATA_IN[`RCS_ST_ILL])
                ill_q <= 1'b0;
            sedge_q <= (sedge_q & ~sclr) | (edges ? sev : 4'h0);
            if (wr && hit_lines)
                sw_q <= rcs_lines_out_t'(PWDATA_IN[6:0]);
            if (wr && hit_ctrl)
            begin
                dir_q <= PWDATA_IN[15:8];
                pdata_q <= PWDATA_IN[23:16];
            end
        end
    end

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    wire [31:0] rd_stat = {29'h0, ill_q, idle_q, data_request_flag_q};
    always_ff @(posedge REF_CLK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
            PRDATA_OUT <= 32'h0000_0000;
        else if (CLK_EN_IN && PSEL_IN && !PENABLE_IN && !PWRITE_IN)
            PRDATA_OUT <= hit_ctrl ? {8'h00, pdata_q, dir_q, 6'h00, mode_q}
                : hit_ior ? {24'h0, ior_q}
                : hit_stat ? rd_stat
                : hit_lines ? {20'h0, 6'(LINES_IN), 6'h00}
                : hit_sedge ? {28'h0, sedge_q}
                : 32'h0000_0000;
    end

    // ------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------
    wire drive_data = in_pbyte ? LINES_IN.select_in_n
        : (in_nib || in_hbyte) ? 1'b0 : 1'b1;
    assign DATA_OUT = in_pbyte ? ior_q : pdata_q;
    assign DATA_OE_N_OUT = drive_data ? (in_pbyte ? 8'h00 : ~dir_q) : 8'hFF;
    always_comb
    begin
        LINES_OUT = sw_q;
        if (in_nib)
        begin
            LINES_OUT.ack_n = ack_q;
            if (nib_on_q)
            begin
                LINES_OUT.busy = nib_val[3];
                LINES_OUT.perror = nib_val[2];
                LINES_OUT.select = nib_val[1];
                LINES_OUT.fault_n = nib_val[0];
            end
        end
        else if (in_pbyte)
            LINES_OUT.ack_n = ack_q;
        else if (in_hbyte)
        begin
            LINES_OUT.auto_fd_n = auto_q;
            LINES_OUT.strobe_n = strobe_q;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge REF_CLK_IN); endclocking
    default disable iff (!RST_N_IN);
    nib_entry_a: assert property (CLK_EN_IN && ctrl_wr && new_mode == RCS_MODE_PNIB
        |=> data_request_flag_q && idle_q) else $error("nibble entry flags");
    pb_entry_a: assert property (CLK_EN_IN && ctrl_wr && new_mode == RCS_MODE_PBYTE
        |=> data_request_flag_q && idle_q) else $error("byte entry flags");
    hb_idle_a: assert property (CLK_EN_IN && ctrl_wr && new_mode == RCS_MODE_HBYTE
        |=> !idle_q && DATA_OE_N_OUT == 8'hFF) else $error("host byte entry");
    nib_data_a: assert property (in_nib |-> DATA_OE_N_OUT == 8'hFF)
        else $error("nibble data driven");
    load_a: assert property (CLK_EN_IN && load |=> ior_q == $past(ohr_q))
        else $error("byte not loaded");
    hb_quiet_a: assert property (in_hbyte && !ctrl_wr |=> $stable(sedge_q) || $fell(|sedge_q)
        || !in_hbyte) else $error("host byte event");
    latch_a: assert property (CLK_EN_IN && take_in |=> ior_q == $past(DATA_IN) && data_request_flag_q)
        else $error("host byte latch");
    ill_pb_a: assert property (CLK_EN_IN && pb_bad && !ctrl_wr |=> ill_q)
        else $error("illegal not flagged");
    pb_drive_a: assert property (in_pbyte && LINES_IN.select_in_n |-> DATA_OE_N_OUT == 8'h00)
        else $error("byte data not driven");
    nib_cv: cover property (st_q == RCS_S_HIGHLO ##[1:200] st_q == RCS_S_REST);
    hb_cv: cover property (st_q == RCS_S_SWAIT ##[1:200] st_q == RCS_S_STROBE);
    pb_cv: cover property (st_q == RCS_S_HWAIT ##[1:200] st_q == RCS_S_RISE);
endmodule

//--- inc/rcs_defines.svh
// Purpose: Constants for the reverse channel sequencer
// Assumes: 125 MHz reference clock
// Notes: Offsets are byte addresses on the APB register port
`ifndef RCS_DEFINES_SVH
`define RCS_DEFINES_SVH
`define RCS_OFF_CTRL 12'h000
`define RCS_OFF_OHR 12'h004
`define RCS_OFF_IOR 12'h008
`define RCS_OFF_STAT 12'h00C
`define RCS_OFF_LINES 12'h010
`define RCS_OFF_SEDGE 12'h014
`define RCS_CLK_MHZ 125
`define RCS_SETUP_NS 500
`define RCS_SETUP_CYC ((`RCS_SETUP_NS * `RCS_CLK_MHZ + 999) / 1000)
`define RCS_ST_DATA_REQUEST_FLAG 0
`define RCS_ST_IDLE 1
`define RCS_ST_ILL 2
`endif

//--- inc/rcs_pkg.sv
// Purpose: Types for the reverse channel sequencer
// Assumes: Nothing beyond the defines header
// Notes: Mode codes are software visible in the control register
package rcs_pkg;
    typedef enum logic [1:0]
    {
        RCS_MODE_SW = 2'b00,
        RCS_MODE_PNIB = 2'b01,
        RCS_MODE_HBYTE = 2'b10,
        RCS_MODE_PBYTE = 2'b11
    } rcs_mode_t;
    typedef enum logic [3:0]
    {
        RCS_S_IDLE = 4'b0000,
        RCS_S_SETUP = 4'b0001,
        RCS_S_ACKLO = 4'b0010,
        RCS_S_WAITHI = 4'b0011,
        RCS_S_WAITLO = 4'b0100,
        RCS_S_HIGHLO = 4'b0101,
        RCS_S_HIGHWT = 4'b0110,
        RCS_S_REST = 4'b0111,
        RCS_S_RISE = 4'b1000,
        RCS_S_STROBE = 4'b1001,
        RCS_S_SWAIT = 4'b1010,
        RCS_S_HWAIT = 4'b1011,
        RCS_S_START = 4'b1100
    } rcs_state_t;
    // Host-to-device control lines, sampled synchronously
    typedef struct packed
    {
        logic select_in_n;
        logic init_n;
        logic auto_fd_n;
        logic strobe_n;
        logic fault_n;
        logic ack_n;
    } rcs_lines_in_t;
    // Device-driven control lines
    typedef struct packed
    {
        logic busy;
        logic perror;
        logic select;
        logic fault_n;
        logic ack_n;
        logic auto_fd_n;
        logic strobe_n;
    } rcs_lines_out_t;
endpackage

//--- test/rcs_far_end.sv
// Purpose: Remote 1284 party facing the reverse channel sequencer
// Assumes: Role follows the mode code: 1 nibble host, 2 byte peripheral, 3 byte host
// Notes: Changing role aborts the handshake in flight; afd, stb and ack go high, flt goes low
`timescale 1ns/100ps
module rcs_far_end
(
    input wire logic clk_in,
    input wire logic [1:0] role_in,
    input wire logic [1:0] ctl_in,
    input wire logic [7:0] send_in,
    input wire logic [7:0] n_in,
    input wire rcs_pkg::rcs_lines_out_t lines_in,
    input wire logic [7:0] data_in,
    output rcs_pkg::rcs_lines_in_t lines_out,
    output logic [7:0] data_out,
    output logic [7:0] got_out,
    output int got_cnt_out
);
    import rcs_pkg::*;
    logic afd = 1'h1;
    logic stb = 1'h1;
    logic flt = 1'h1;
    logic ack = 1'h1;
    int k;
    assign lines_out = {ctl_in, afd, stb, flt, ack};
    initial got_cnt_out = 0;
    initial data_out = 8'h00;
    always @(role_in) disable run_blk;
    // Undriven data lines keep changing so stale values never pass
    always @(posedge clk_in) if (role_in != 2'h2) data_out <= ~data_out;
    initial forever
    begin : run_blk
        afd <= 1'h1;
        stb <= 1'h1;
        flt <= 1'h0;
        ack <= 1'h1;
        k = 0;
        @(posedge clk_in);
        case (role_in)
            2'h1: forever
            begin
                wait (lines_in.ack_n == 1'h1);
                @(posedge clk_in);
                afd <= 1'h0;
                wait (lines_in.ack_n == 1'h0);
                @(posedge clk_in);
                got_out[3:0] = {lines_in.busy, lines_in.perror, lines_in.select, lines_in.fault_n};
                afd <= 1'h1;
                wait (lines_in.ack_n == 1'h1);
                @(posedge clk_in);
                afd <= 1'h0;
                wait (lines_in.ack_n == 1'h0);
                @(posedge clk_in);
                got_out[7:4] = {lines_in.busy, lines_in.perror, lines_in.select, lines_in.fault_n};
                afd <= 1'h1;
                got_cnt_out++;
            end
            2'h2: forever
            begin
                wait (lines_in.auto_fd_n == 1'h0);
                @(posedge clk_in);
                data_out <= send_in + 8'(k);
                ack <= 1'h0;
                wait (lines_in.auto_fd_n == 1'h1);
                @(posedge clk_in);
                ack <= 1'h1;
                data_out <= ~data_out;
                k++;
                flt <= (k < n_in) ? 1'h0 : 1'h1;
            end
            2'h3: forever
            begin
                @(posedge clk_in);
                afd <= 1'h0;
                wait (lines_in.ack_n == 1'h0);
                @(posedge clk_in);
                got_out = data_in;
                got_cnt_out++;
                afd <= 1'h1;
                wait (lines_in.ack_n == 1'h1);
                @(posedge clk_in);
                stb <= 1'h0;
                @(posedge clk_in);
                stb <= 1'h1;
            end
            default: ;
        endcase
    end
endmodule

//--- test/ieee1284_reverse_channel_sequencer_bench.sv
// Purpose: Self-checking bench for the reverse channel sequencer
// Assumes: Short handshake delay of 4 cycles
// Notes: Remote party is modelled in rcs_far_end
`timescale 1ns/100ps
`include "rcs_defines.svh"
module ieee1284_reverse_channel_sequencer_bench;
    import rcs_pkg::*;
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    rcs_lines_in_t fe_lines;
    rcs_lines_out_t sq_lines;
    logic [7:0] fe_data;
    logic [7:0] sq_data;
    logic [7:0] oe_n;
    logic [1:0] role = 2'h0;
    logic [1:0] ctl = 2'h3;
    logic [7:0] got;
    int got_cnt;
    int bad_count = 0;
    int total_checks = 0;
    logic [31:0] rd;
    logic er;
    always #4 clk = ~clk;
    rcs_seq #(.SETUP_CYC(4)) dut_u (.REF_CLK_IN(clk), .RST_N_IN(rst_n), .CLK_EN_IN(1'h1),
        .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr),
        .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
        .LINES_IN(fe_lines), .LINES_OUT(sq_lines), .DATA_IN(fe_data), .DATA_OUT(sq_data),
        .DATA_OE_N_OUT(oe_n));
    rcs_far_end far_u (.clk_in(clk), .role_in(role), .ctl_in(ctl), .send_in(8'h5A),
        .n_in(8'h02), .lines_in(sq_lines), .data_in(sq_data), .lines_out(fe_lines),
        .data_out(fe_data), .got_out(got), .got_cnt_out(got_cnt));
    // ----------------------------------------
    // Bus and compare tasks
    // ----------------------------------------
    task automatic end_of_test;
        if (bad_count == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        @(posedge clk);
        while (pready !== 1'h1)
            @(posedge clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'h1, a, d);
    endtask
    task automatic rc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'h0, a, 32'h0);
        chk(rd & m, e);
    endtask
    task automatic poll(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        for (int i = 0; i < 100; i++)
        begin
            apb(1'h0, a, 32'h0);
            if ((rd & m) === e)
                break;
        end
        chk(rd & m, e);
    endtask
    task automatic wait_got(input int n, input logic [7:0] e);
        for (int i = 0; i < 3000 && got_cnt < n; i++)
            @(posedge clk);
        chk(32'(got_cnt), 32'(n));
        chk({24'h0, got}, {24'h0, e});
    endtask
    task automatic pulse_ctl(input logic [1:0] v);
        @(posedge clk);
        ctl <= v;
        @(posedge clk);
        ctl <= 2'h3;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic s_regs;
        rc(`RCS_OFF_STAT, 32'h7, 32'h0);
        rc(12'h020, 32'hFFFFFFFF, 32'h0);
        chk({31'h0, er}, 32'h1);
    endtask
    task automatic s_nibble;
        role <= 2'h1;
        wr(`RCS_OFF_CTRL, 32'h1);
        rc(`RCS_OFF_STAT, 32'h7, 32'h3);
        chk({24'h0, oe_n}, 32'hFF);
        wr(`RCS_OFF_OHR, 32'hA5);
        rc(`RCS_OFF_STAT, 32'h2, 32'h0);
        wait_got(1, 8'hA5);
        poll(`RCS_OFF_STAT, 32'h3, 32'h3);
        chk({28'h0, sq_lines.busy, sq_lines.perror, sq_lines.select, sq_lines.fault_n}, 32'hF);
        wr(`RCS_OFF_OHR, 32'h3C);
        wait_got(2, 8'h3C);
        pulse_ctl(2'h2);
        poll(`RCS_OFF_SEDGE, 32'hF, 32'hC);
        wr(`RCS_OFF_SEDGE, 32'hF);
        poll(`RCS_OFF_STAT, 32'h3, 32'h3);
        pulse_ctl(2'h0);
        poll(`RCS_OFF_SEDGE, 32'hF, 32'hF);
        rc(`RCS_OFF_STAT, 32'h4, 32'h4);
        wr(`RCS_OFF_STAT, 32'h4);
        wr(`RCS_OFF_SEDGE, 32'hF);
        wr(`RCS_OFF_LINES, 32'h7F);
    endtask
    task automatic s_hbyte;
        role <= 2'h2;
        wr(`RCS_OFF_CTRL, 32'hFF02);
        rc(`RCS_OFF_STAT, 32'h2, 32'h0);
        chk({24'h0, oe_n}, 32'hFF);
        // Take the byte left from nibble mode so the first capture can go
        apb(1'h0, `RCS_OFF_IOR, 32'h0);
        poll(`RCS_OFF_STAT, 32'h1, 32'h1);
        rc(`RCS_OFF_IOR, 32'hFF, 32'h5A);
        pulse_ctl(2'h2);
        poll(`RCS_OFF_STAT, 32'h3, 32'h1);
        rc(`RCS_OFF_IOR, 32'hFF, 32'h5B);
        poll(`RCS_OFF_STAT, 32'h2, 32'h2);
        rc(`RCS_OFF_SEDGE, 32'hF, 32'h0);
    endtask
    task automatic s_pbyte;
        role <= 2'h3;
        wr(`RCS_OFF_CTRL, 32'h3);
        rc(`RCS_OFF_STAT, 32'h7, 32'h3);
        chk({24'h0, oe_n}, 32'h0);
        wr(`RCS_OFF_OHR, 32'hC3);
        rc(`RCS_OFF_STAT, 32'h2, 32'h0);
        wait_got(3, 8'hC3);
        poll(`RCS_OFF_STAT, 32'h3, 32'h3);
        wr(`RCS_OFF_OHR, 32'h81);
        wait_got(4, 8'h81);
        poll(`RCS_OFF_STAT, 32'h3, 32'h3);
        ctl <= 2'h1;
        poll(`RCS_OFF_STAT, 32'h4, 32'h4);
        rc(`RCS_OFF_SEDGE, 32'h2, 32'h2);
        chk({24'h0, oe_n}, 32'hFF);
        wr(`RCS_OFF_CTRL, 32'h0);
    endtask
    initial
    begin
        repeat (3) @(posedge clk);
        rst_n <= 1'h1;
        s_regs();
        s_nibble();
        s_hbyte();
        s_pbyte();
        end_of_test();
    end
    initial
    begin
        #200000;
        bad_count++;
        end_of_test();
    end
endmodule
